// >>> src/chan_evt_pkg.sv
package chan_evt_pkg;

  // ==========================================================================
  // kernel modes and shared size constants
  // ==========================================================================
  typedef enum logic [1:0]
  {
    KM_RUN0  = 2'b00,
    KM_RUN1  = 2'b01,
    KM_STOP0 = 2'b10,
    KM_STOP1 = 2'b11
  } kmode_t;

  localparam int KMODE_W = 2;
  localparam int NODE_W  = 2;
  localparam int N_SR    = 4;
  localparam int ST_W    = 9;

  // protocol selection
  typedef enum logic [1:0]
  {
    PROTO_SYNC  = 2'b00,
    PROTO_ASYNC = 2'b01,
    PROTO_I2S   = 2'b10,
    PROTO_I2C   = 2'b11
  } proto_t;

  // kernel_state_config field positions
  localparam int KS_MODULE_ENABLE_BIT    = 0;
  localparam int KS_MODULE_ENABLE_PROTECT  = 1;
  localparam int KS_NOM_LO   = 4;
  localparam int KS_BPNOM    = 7;
  localparam int KS_SUM_LO   = 8;
  localparam int KS_BPSUM    = 11;
  localparam int KS_COM_LO   = 12;
  localparam int KS_BPCOM    = 15;
  localparam logic [15:0] KERNEL_STATE_CONFIG_RST = 16'h0000;

  // event flag positions in the data-event vector
  localparam int EV_RX  = 0;
  localparam int EV_RS  = 1;
  localparam int EV_ALT = 2;
  localparam int EV_TS  = 3;
  localparam int EV_TB  = 4;
  localparam int EV_DL  = 5;
  localparam int N_EV   = 6;

  // protocol event masks (which status bits may set per protocol)
  localparam logic [ST_W-1:0] PMASK_ASYNC = 9'h1fc;
  localparam logic [ST_W-1:0] PMASK_SYNC  = 9'h00c;
  localparam logic [ST_W-1:0] PMASK_I2C   = 9'h1fe;
  localparam logic [ST_W-1:0] PMASK_I2S   = 9'h078;

  // per-word receive/transmit strobes from the shift engine
  typedef struct packed
  {
    logic rx_word;
    logic rx_special;
    logic rx_start;
    logic tx_shift_last;
    logic tx_first_bit;
    logic rx_overwrite;
  } xfer_strobe_t;

  // node pointers; rx start uses tx_buffer, data lost uses proto
  typedef struct packed
  {
    logic [NODE_W-1:0] rx;
    logic [NODE_W-1:0] alt_rx;
    logic [NODE_W-1:0] tx_shift;
    logic [NODE_W-1:0] tx_buffer;
    logic [NODE_W-1:0] proto;
  } node_ptr_t;

endpackage

// >>> src/event_flag.sv
module event_flag
  import chan_evt_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_r
);

  // sticky flag, a set in the clear cycle wins
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      flag_r <= 1'b0;
    else if (set_i)
      flag_r <= 1'b1;
    else if (clr_i)
      flag_r <= 1'b0;
  end

endmodule

// >>> src/serial_channel_mode_events.sv
// Summary of operation
// (R1) no suspend or clock-off request: normal state, clock on, normal kernel mode
// (R2) suspend request pending: suspend state, registers stay open, suspend mode field
// (R3) clock-off: gate clock only after all channels stopped, then block access
// (R4) kernel code 00/01 run, 10/11 stop at protocol stop condition
// (R5) software should set normal field to run mode 0
// (R6) software copies normal code to suspend field to ignore suspend
// (R7) software should not mix the two stop modes
// (R8) module disabled or clock gated: ignore all but kernel config access
// (R9) detected event sets its flag, held until software clears it
// (R10) enabled event pulses a request every time, flag state irrelevant
// (R11) node pointer picks service output; events may share one
// (R12) new word with special bit 0 raises receive event
// (R13) new word with special bit 1 raises alternative receive event
// (R14) special bit: parity, first byte, word address; zero in sync mode
// (R15) receiver start event sets flag, routed via tx buffer pointer
// (R16) receiver start follows tx buffer event by half shift clock
// (R17) single shot: data valid cleared by rx start or tx buffer event
// (R18) last shift edge of word raises transmit shift event
// (R19) first bit shifted out raises transmit buffer event
// (R20) overwritten unread word raises data lost via protocol pointer
// (R21) six data events each with flag, clear, enable, pointer
// (R22) protocol events individually enabled, one protocol request, mode masks
// (R23) protected fields update only with protect bit set same access
// (R24) write-only bits read zero
// (R25) clear bit written one clears flag, zero leaves it
module serial_channel_mode_events
  import chan_evt_pkg::*;
#(
  parameter int NSR = N_SR
)
(
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  input  wire logic                          suspend_req,
  input  wire logic                          clockoff_req,
  input  wire logic                          all_chan_stopped,
  input  wire logic                          stop_cond_reached,
  input  wire logic                          ks_wr,
  input  wire logic [15:0]                   ks_wdata,
  input  wire logic                          reg_access,
  input  wire chan_evt_pkg::proto_t          proto_sel,
  input  wire chan_evt_pkg::xfer_strobe_t    xfer,
  input  wire logic                          single_shot,
  input  wire logic                          tx_valid_set,
  input  wire logic [ST_W-1:0]               proto_event,
  input  wire logic [ST_W-1:0]               proto_irq_en,
  input  wire logic [N_EV-1:0]               event_irq_en,
  input  wire chan_evt_pkg::node_ptr_t       node_ptr,
  input  wire logic                          clr_wr,
  input  wire logic [N_EV+ST_W-1:0]          clr_wdata,
  output logic [15:0]                        ks_rdata_r,
  output logic [1:0]                         op_state_r,
  output logic [KMODE_W-1:0]                 active_kmode_r,
  output logic                               halt_r,
  output logic                               clk_gate_off_r,
  output logic                               access_ok_r,
  output logic                               access_ignored_r,
  output logic [N_EV-1:0]                    data_flags_r,
  output logic [ST_W-1:0]                    proto_status_bits_r,
  output logic                               rx_special_bit_r,
  output logic                               tx_data_valid_r,
  output logic [NSR-1:0]                     service_request_out_r
);
  import chan_evt_pkg::*;

  // ==========================================================================
  // kernel state configuration
  // ==========================================================================
  logic   module_enable_bit_r;
  kmode_t normal_state_kmode_r;
  kmode_t suspend_state_kmode_r;
  kmode_t clockoff_state_kmode_r;

  // protected field writes
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      module_enable_bit_r    <= KERNEL_STATE_CONFIG_RST[KS_MODULE_ENABLE_BIT];
      normal_state_kmode_r   <= kmode_t'(KERNEL_STATE_CONFIG_RST[KS_NOM_LO +: KMODE_W]);
      suspend_state_kmode_r  <= kmode_t'(KERNEL_STATE_CONFIG_RST[KS_SUM_LO +: KMODE_W]);
      clockoff_state_kmode_r <= kmode_t'(KERNEL_STATE_CONFIG_RST[KS_COM_LO +: KMODE_W]);
    end
    else if (ks_wr)
    begin
      if (ks_wdata[KS_MODULE_ENABLE_PROTECT])
        module_enable_bit_r <= ks_wdata[KS_MODULE_ENABLE_BIT]; // R23
      if (ks_wdata[KS_BPNOM])
        normal_state_kmode_r <= kmode_t'(ks_wdata[KS_NOM_LO +: KMODE_W]); // R23
      if (ks_wdata[KS_BPSUM])
        suspend_state_kmode_r <= kmode_t'(ks_wdata[KS_SUM_LO +: KMODE_W]); // R23
      if (ks_wdata[KS_BPCOM])
        clockoff_state_kmode_r <= kmode_t'(ks_wdata[KS_COM_LO +: KMODE_W]); // R23
    end
  end

  // read-back, protect bits always zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ks_rdata_r <= 16'h0000;
    else
    begin
      ks_rdata_r                          <= 16'h0000; // R24
      ks_rdata_r[KS_MODULE_ENABLE_BIT]                <= module_enable_bit_r;
      ks_rdata_r[KS_NOM_LO +: KMODE_W]    <= normal_state_kmode_r;
      ks_rdata_r[KS_SUM_LO +: KMODE_W]    <= suspend_state_kmode_r;
      ks_rdata_r[KS_COM_LO +: KMODE_W]    <= clockoff_state_kmode_r;
    end
  end

  // ==========================================================================
  // operating state and kernel mode
  // ==========================================================================
  typedef enum logic [1:0] {ST_NORMAL, ST_SUSPEND, ST_CLOCKOFF} opstate_t;
  opstate_t state_nxt;
  kmode_t   kmode_nxt;

  // clock-off outranks suspend
  always_comb
  begin
    if (clockoff_req)
    begin
      state_nxt = ST_CLOCKOFF;
      kmode_nxt = clockoff_state_kmode_r; // R3
    end
    else if (suspend_req)
    begin
      state_nxt = ST_SUSPEND;
      kmode_nxt = suspend_state_kmode_r; // R2
    end
    else
    begin
      state_nxt = ST_NORMAL;
      kmode_nxt = normal_state_kmode_r; // R1
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_state_r     <= 2'h0;
      active_kmode_r <= KM_RUN0;
    end
    else
    begin
      op_state_r     <= state_nxt;
      active_kmode_r <= kmode_nxt;
    end
  end

  // halt on stop mode once the protocol stop point is hit
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      halt_r <= 1'b0;
    else
      halt_r <= kmode_nxt[1] && stop_cond_reached; // R4
  end

  // clock gate: module disabled, or clock-off in stop mode with all channels stopped
  logic gate_nxt;
  assign gate_nxt = !module_enable_bit_r ||
                    (clockoff_req && clockoff_state_kmode_r[1] && all_chan_stopped); // R3

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      clk_gate_off_r <= 1'b1;
    else
      clk_gate_off_r <= gate_nxt;
  end

  // access admission for all registers other than kernel config
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      access_ok_r      <= 1'b0;
      access_ignored_r <= 1'b0;
    end
    else
    begin
      access_ok_r      <= reg_access && !gate_nxt; // R8
      access_ignored_r <= reg_access && gate_nxt; // R8
    end
  end

  // ==========================================================================
  // data transfer events
  // ==========================================================================
  logic            live;
  logic            special;
  logic [N_EV-1:0] ev;

  assign live    = module_enable_bit_r && !halt_r;
  assign special = (proto_sel != PROTO_SYNC) && xfer.rx_special; // R14

  always_comb
  begin
    ev         = '0;
    ev[EV_RX]  = live && xfer.rx_word && !special; // R12
    ev[EV_ALT] = live && xfer.rx_word && special; // R13
    ev[EV_RS]  = live && xfer.rx_start; // R15 R16
    ev[EV_TS]  = live && xfer.tx_shift_last; // R18
    ev[EV_TB]  = live && xfer.tx_first_bit; // R19
    ev[EV_DL]  = live && xfer.rx_overwrite; // R20
  end

  // one sticky flag per data event
  for (genvar i = 0; i < N_EV; i++)
  begin : g_dflag
    event_flag u_flag
    (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .set_i   (ev[i]), // R9
      .clr_i   (clr_wr && clr_wdata[i]), // R21 R25
      .flag_r  (data_flags_r[i])
    );
  end

  // special bit of the most recent word
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rx_special_bit_r <= 1'b0;
    else if (live && xfer.rx_word)
      rx_special_bit_r <= special; // R14
  end

  // ==========================================================================
  // protocol events
  // ==========================================================================
  logic [ST_W-1:0] pmask;
  logic [ST_W-1:0] pev;

  always_comb
  begin
    case (proto_sel)
      PROTO_ASYNC: pmask = PMASK_ASYNC;
      PROTO_SYNC:  pmask = PMASK_SYNC;
      PROTO_I2C:   pmask = PMASK_I2C;
      default:     pmask = PMASK_I2S;
    endcase
  end

  assign pev = live ? (proto_event & pmask) : '0; // R22

  for (genvar j = 0; j < ST_W; j++)
  begin : g_pflag
    event_flag u_flag
    (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .set_i   (pev[j]), // R9
      .clr_i   (clr_wr && clr_wdata[N_EV+j]), // R25
      .flag_r  (proto_status_bits_r[j])
    );
  end

  // ==========================================================================
  // transmit data valid, single shot clear
  // ==========================================================================
  logic tdv_clr;
  assign tdv_clr = single_shot &&
                   (((proto_sel == PROTO_SYNC || proto_sel == PROTO_I2S) && ev[EV_RS]) ||
                    ((proto_sel == PROTO_ASYNC || proto_sel == PROTO_I2C) && ev[EV_TB])); // R17

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tx_data_valid_r <= 1'b0;
    else if (tx_valid_set)
      tx_data_valid_r <= 1'b1;
    else if (tdv_clr)
      tx_data_valid_r <= 1'b0; // R17
  end

  // ==========================================================================
  // service request routing
  // ==========================================================================
  logic [NSR-1:0] sr_nxt;
  logic           proto_irq;

  assign proto_irq = |(pev & proto_irq_en); // R22

  // pulse each cycle an enabled event fires, flag ignored
  always_comb
  begin
    sr_nxt = '0;
    if (ev[EV_RX] && event_irq_en[EV_RX])
      sr_nxt[node_ptr.rx] = 1'b1; // R10 R11
    if (ev[EV_ALT] && event_irq_en[EV_ALT])
      sr_nxt[node_ptr.alt_rx] = 1'b1; // R11
    if (ev[EV_TS] && event_irq_en[EV_TS])
      sr_nxt[node_ptr.tx_shift] = 1'b1; // R11
    if (ev[EV_TB] && event_irq_en[EV_TB])
      sr_nxt[node_ptr.tx_buffer] = 1'b1; // R11
    if (ev[EV_RS] && event_irq_en[EV_RS])
      sr_nxt[node_ptr.tx_buffer] = 1'b1; // R15
    if (ev[EV_DL] && event_irq_en[EV_DL])
      sr_nxt[node_ptr.proto] = 1'b1; // R20
    if (proto_irq)
      sr_nxt[node_ptr.proto] = 1'b1; // R22
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      service_request_out_r <= '0;
    else
      service_request_out_r <= sr_nxt;
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  property p_flag_set;
    @(posedge ref_clk) disable iff (!nrst)
    ev[EV_RX] |=> data_flags_r[EV_RX];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("rx flag not set"); // R9

  property p_sr_pulse;
    @(posedge ref_clk) disable iff (!nrst)
    (ev[EV_RX] && event_irq_en[EV_RX] && data_flags_r[EV_RX]) |=> service_request_out_r[$past(node_ptr.rx)];
  endproperty
  a_sr_pulse: assert property (p_sr_pulse) else $error("request missing with flag set"); // R10

  property p_rs_route;
    @(posedge ref_clk) disable iff (!nrst)
    (ev[EV_RS] && event_irq_en[EV_RS]) |=> service_request_out_r[$past(node_ptr.tx_buffer)];
  endproperty
  a_rs_route: assert property (p_rs_route) else $error("rx start not routed"); // R15

  property p_alt_split;
    @(posedge ref_clk) disable iff (!nrst)
    !(ev[EV_RX] && ev[EV_ALT]);
  endproperty
  a_alt_split: assert property (p_alt_split) else $error("both receive events"); // R13

  property p_sync_special;
    @(posedge ref_clk) disable iff (!nrst)
    (live && xfer.rx_word && proto_sel == PROTO_SYNC) |=> !rx_special_bit_r;
  endproperty
  a_sync_special: assert property (p_sync_special) else $error("special bit in sync"); // R14

  property p_gate;
    @(posedge ref_clk) disable iff (!nrst)
    (module_enable_bit_r && !clockoff_req) |=> !clk_gate_off_r;
  endproperty
  a_gate: assert property (p_gate) else $error("clock gated early"); // R3

  property p_ignore;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_access && !module_enable_bit_r) |=> (access_ignored_r && !access_ok_r);
  endproperty
  a_ignore: assert property (p_ignore) else $error("access not ignored"); // R8

  property p_protect;
    @(posedge ref_clk) disable iff (!nrst)
    (ks_wr && !ks_wdata[KS_BPNOM]) |=> $stable(normal_state_kmode_r);
  endproperty
  a_protect: assert property (p_protect) else $error("unprotected write landed"); // R23

  property p_clear;
    @(posedge ref_clk) disable iff (!nrst)
    (clr_wr && clr_wdata[EV_TS] && !ev[EV_TS]) |=> !data_flags_r[EV_TS];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // R25

  property p_tdv;
    @(posedge ref_clk) disable iff (!nrst)
    (tdv_clr && !tx_valid_set) |=> !tx_data_valid_r;
  endproperty
  a_tdv: assert property (p_tdv) else $error("data valid not cleared"); // R17

  property p_susp;
    @(posedge ref_clk) disable iff (!nrst)
    (suspend_req && !clockoff_req) |=> active_kmode_r == $past(suspend_state_kmode_r);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend mode wrong"); // R2

  c_rx: cover property (@(posedge ref_clk) disable iff (!nrst) ev[EV_RX] ##1 service_request_out_r != '0);
  c_gate: cover property (@(posedge ref_clk) disable iff (!nrst) clockoff_req ##1 clk_gate_off_r);
  c_tdv: cover property (@(posedge ref_clk) disable iff (!nrst) tx_data_valid_r ##1 !tx_data_valid_r);

endmodule

// >>> dv/state_ctrl_model.sv
module state_ctrl_model
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic want_suspend,
  input  wire logic want_clockoff,
  input  wire logic chan_halted,
  output logic      suspend_req,
  output logic      clockoff_req,
  output logic      all_chan_stopped
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // device state requests
  // ==========================================================================
  // requests follow the wanted state one edge later
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      suspend_req  <= 1'b0;
      clockoff_req <= 1'b0;
    end
    else
    begin
      suspend_req  <= want_suspend;
      clockoff_req <= want_clockoff;
    end
  end

  // single channel: its stop report stands for the whole module
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      all_chan_stopped <= 1'b0;
    else
      all_chan_stopped <= clockoff_req & chan_halted;
  end
endmodule

// >>> dv/test_serial_channel_mode_events.sv
module test_serial_channel_mode_events;
  import chan_evt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // stimulus and observed signals
  // ==========================================================================
  logic                 ref_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 want_suspend = 1'b0;
  logic                 want_clockoff = 1'b0;
  logic                 stop_cond_reached = 1'b0;
  logic                 ks_wr = 1'b0;
  logic [15:0]          ks_wdata = 16'h0000;
  logic                 reg_access = 1'b0;
  proto_t               proto_sel = PROTO_ASYNC;
  xfer_strobe_t         xfer = 6'h00;
  logic                 single_shot = 1'b0;
  logic                 tx_valid_set = 1'b0;
  logic [ST_W-1:0]      proto_event = 9'h000;
  logic [ST_W-1:0]      proto_irq_en = 9'h000;
  logic [N_EV-1:0]      event_irq_en = 6'h00;
  node_ptr_t            node_ptr = 10'h06d;
  logic                 clr_wr = 1'b0;
  logic [N_EV+ST_W-1:0] clr_wdata = 15'h0000;
  logic                 suspend_req;
  logic                 clockoff_req;
  logic                 all_chan_stopped;
  logic [15:0]          ks_rdata_r;
  logic [1:0]           op_state_r;
  logic [KMODE_W-1:0]   active_kmode_r;
  logic                 halt_r;
  logic                 clk_gate_off_r;
  logic                 access_ok_r;
  logic                 access_ignored_r;
  logic [N_EV-1:0]      data_flags_r;
  logic [ST_W-1:0]      proto_status_bits_r;
  logic                 rx_special_bit_r;
  logic                 tx_data_valid_r;
  logic [N_SR-1:0]      service_request_out_r;
  int                   miscompares = 0;
  int                   compares = 0;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  state_ctrl_model state_ctrl_model_i (.ref_clk(ref_clk), .nrst(nrst), .want_suspend(want_suspend),
    .want_clockoff(want_clockoff), .chan_halted(halt_r), .suspend_req(suspend_req),
    .clockoff_req(clockoff_req), .all_chan_stopped(all_chan_stopped));

  serial_channel_mode_events #(.NSR(N_SR)) serial_channel_mode_events_i (.ref_clk(ref_clk), .nrst(nrst),
    .suspend_req(suspend_req), .clockoff_req(clockoff_req), .all_chan_stopped(all_chan_stopped),
    .stop_cond_reached(stop_cond_reached), .ks_wr(ks_wr), .ks_wdata(ks_wdata), .reg_access(reg_access),
    .proto_sel(proto_sel), .xfer(xfer), .single_shot(single_shot), .tx_valid_set(tx_valid_set),
    .proto_event(proto_event), .proto_irq_en(proto_irq_en), .event_irq_en(event_irq_en),
    .node_ptr(node_ptr), .clr_wr(clr_wr), .clr_wdata(clr_wdata), .ks_rdata_r(ks_rdata_r),
    .op_state_r(op_state_r), .active_kmode_r(active_kmode_r), .halt_r(halt_r),
    .clk_gate_off_r(clk_gate_off_r), .access_ok_r(access_ok_r), .access_ignored_r(access_ignored_r),
    .data_flags_r(data_flags_r), .proto_status_bits_r(proto_status_bits_r),
    .rx_special_bit_r(rx_special_bit_r), .tx_data_valid_r(tx_data_valid_r),
    .service_request_out_r(service_request_out_r));

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one-cycle strobe, answer sampled mid-cycle after it is taken
  task automatic fire(input logic [5:0] x, input logic [ST_W-1:0] p);
    @(posedge ref_clk);
    xfer <= x;
    proto_event <= p;
    @(posedge ref_clk);
    xfer <= 6'h00;
    proto_event <= 9'h000;
    @(negedge ref_clk);
  endtask

  task automatic ks_write(input logic [15:0] d);
    @(posedge ref_clk);
    ks_wr <= 1'b1;
    ks_wdata <= d;
    @(posedge ref_clk);
    ks_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic clear(input logic [N_EV+ST_W-1:0] d);
    @(posedge ref_clk);
    clr_wr <= 1'b1;
    clr_wdata <= d;
    @(posedge ref_clk);
    clr_wr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic access();
    @(posedge ref_clk);
    reg_access <= 1'b1;
    @(posedge ref_clk);
    reg_access <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_kernel_state_config();
    chk(ks_rdata_r, KERNEL_STATE_CONFIG_RST, "kernel_state_config reset value");
    chk(clk_gate_off_r, 1'b1, "clock gated while disabled");
    access();
    chk(access_ignored_r, 1'b1, "access while disabled");
    ks_write(16'h0083);
    chk(ks_rdata_r, 16'h0001, "enable with protect");
    chk(clk_gate_off_r, 1'b0, "clock running");
    ks_write(16'h0030);
    chk(ks_rdata_r, 16'h0001, "unprotected write");
    ks_write(16'h0a90);
    chk(ks_rdata_r, 16'h0211, "protected fields");
    chk(active_kmode_r, KM_RUN1, "normal kmode");
    access();
    chk(access_ok_r, 1'b1, "access accepted");
    $display("test kernel_state_config done");
  endtask

  task automatic t_events();
    logic [5:0] strobe [N_EV];
    logic [1:0] node [N_EV];
    strobe = '{6'h20, 6'h08, 6'h30, 6'h04, 6'h02, 6'h01};
    node = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h3, 2'h1};
    @(posedge ref_clk);
    event_irq_en <= 6'h3f;
    for (int e = 0; e < N_EV; e++)
    begin
      repeat (2)
      begin
        fire(strobe[e], 9'h000);
        chk(data_flags_r[e], 1'b1, "flag set");
        chk(service_request_out_r, 4'h1 << node[e], "request routed");
      end
      if (e == EV_ALT)
        chk(rx_special_bit_r, 1'b1, "special bit async");
    end
    chk(data_flags_r, 6'h3f, "flags held");
    clear(15'h0005);
    chk(data_flags_r, 6'h3a, "selective clear");
    clear(15'h003f);
    @(posedge ref_clk);
    event_irq_en <= 6'h3e;
    fire(6'h20, 9'h000);
    chk(data_flags_r, 6'h01, "flag without enable");
    chk(service_request_out_r, 4'h0, "no request when disabled");
    $display("test events done");
  endtask

  task automatic t_proto();
    proto_t mode [4];
    logic [ST_W-1:0] mask [4];
    mode = '{PROTO_ASYNC, PROTO_SYNC, PROTO_I2C, PROTO_I2S};
    mask = '{9'h1fc, 9'h00c, 9'h1fe, 9'h078};
    @(posedge ref_clk);
    proto_irq_en <= 9'h1ff;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      proto_sel <= mode[i];
      clear(15'h7fff);
      fire(6'h00, 9'h1ff);
      chk(proto_status_bits_r, mask[i], "protocol mask");
      chk(service_request_out_r, 4'h1 << node_ptr.proto, "protocol request");
    end
    @(posedge ref_clk);
    proto_sel <= PROTO_SYNC;
    clear(15'h7fff);
    fire(6'h30, 9'h000);
    chk(rx_special_bit_r, 1'b0, "special bit sync");
    chk(data_flags_r, 6'h01, "sync word is plain receive");
    $display("test proto done");
  endtask

  task automatic t_single_shot();
    proto_t mode [2];
    logic [5:0] keep [2];
    logic [5:0] kill [2];
    mode = '{PROTO_SYNC, PROTO_ASYNC};
    keep = '{6'h02, 6'h08};
    kill = '{6'h08, 6'h02};
    @(posedge ref_clk);
    single_shot <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      proto_sel <= mode[i];
      tx_valid_set <= 1'b1;
      @(posedge ref_clk);
      tx_valid_set <= 1'b0;
      @(negedge ref_clk);
      chk(tx_data_valid_r, 1'b1, "data valid set");
      fire(keep[i], 9'h000);
      chk(tx_data_valid_r, 1'b1, "data valid kept");
      fire(kill[i], 9'h000);
      chk(tx_data_valid_r, 1'b0, "data valid cleared");
    end
    $display("test single shot done");
  endtask

  task automatic t_modes();
    int n;
    ks_write(16'h0880);
    @(posedge ref_clk);
    want_suspend <= 1'b1;
    stop_cond_reached <= 1'b1;
    settle();
    chk(op_state_r, 2'h1, "suspend state");
    chk(halt_r, 1'b0, "suspend ignored");
    ks_write(16'haa80);
    settle();
    chk(ks_rdata_r, 16'h2201, "stop fields");
    chk(active_kmode_r, KM_STOP0, "suspend kmode");
    chk(halt_r, 1'b1, "halted at stop point");
    clear(15'h7fff);
    fire(6'h20, 9'h000);
    chk(data_flags_r, 6'h00, "event refused while halted");
    access();
    chk(access_ok_r, 1'b1, "suspend keeps access");
    @(posedge ref_clk);
    want_clockoff <= 1'b1;
    stop_cond_reached <= 1'b0;
    settle();
    chk(op_state_r, 2'h2, "clock-off state");
    chk(clk_gate_off_r, 1'b0, "no gating before stop");
    @(posedge ref_clk);
    stop_cond_reached <= 1'b1;
    for (n = 0; n < 40 && clk_gate_off_r !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 40)
    begin
      miscompares++;
      $display("BAD %0t clock gating timed out", $time);
      test_done();
    end
    access();
    chk(access_ignored_r, 1'b1, "gated access ignored");
    ks_write(16'h0090);
    chk(ks_rdata_r, 16'h2211, "kernel_state_config open while gated");
    $display("test modes done");
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    t_kernel_state_config();
    t_events();
    t_proto();
    t_single_shot();
    t_modes();
    test_done();
  end
endmodule
